// file: inc/cip_monitor_pkg.sv
// Constants for the component input control and fast-blank monitor block.
// Assumes a host that reaches the registers by sub-address through a decoded
// two-wire control bus port.
// Functional notes
// - Control bit 1 set extends converter range by about 3 dB.
// - Control bit 2 selects input port 1 (0) or port 2 (1).
// - Clamp bit 5 forces fast-blank value to 31 minus offset setting.
// - Control bit 6 bypasses chroma decimation filter; resets to 1.
// - Control bit 7 selects RGB (0) or YUV (1); defaults to 0.
// - High flag set while fast blank high; cleared by read when low.
// - Falling edge of fast blank sets sticky flag; read clears it.
// - Rising edge of fast blank sets sticky flag; read clears it.
// - Monitor bit 3 returns fast-blank level sampled at the read.
// - Input clip sets sticky clip flag; monitor read clears it.
// - Version word bits 7:0 hold hardware revision number.
// - Version word bits 11:8 hold product variant code.
// - Version word bits 15:12 hold product family code.
// - Every control field loads its default value on reset.
// - Fast-blank offset is a 6-bit setting in its own register.
// ============================================================================
package cip_monitor_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int FB_W   = 7;
    localparam int OFFS_W = 6;

    // ========================================================================
    // Sub-addresses.
    localparam logic [ADDR_W-1:0] ADDR_SOFTMIX2 = 8'h95;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL  = 8'h96;
    localparam logic [ADDR_W-1:0] ADDR_MONITOR  = 8'h97;
    localparam logic [ADDR_W-1:0] ADDR_VERSION  = 8'h9F;

    // ========================================================================
    // Control register field positions and reset values.
    localparam int CTL_XAR_BIT    = 1;
    localparam int CTL_PORT_BIT   = 2;
    localparam int CTL_CLAMP_BIT  = 5;
    localparam int CTL_BYPASS_BIT = 6;
    localparam int CTL_YUV_BIT    = 7;
    localparam logic RST_XAR    = 1'b0;
    localparam logic RST_PORT   = 1'b0;
    localparam logic RST_CLAMP  = 1'b0;
    localparam logic RST_BYPASS = 1'b1;
    localparam logic RST_YUV    = 1'b0;

    // ========================================================================
    // Offset setting and clamp base.
    localparam logic [OFFS_W-1:0] RST_OFFSET    = 6'h20;
    localparam logic [FB_W-1:0]   FB_CLAMP_BASE = 7'h1F;

    // ========================================================================
    // Monitor register field positions.
    localparam int MON_HIGH_BIT = 0;
    localparam int MON_FALL_BIT = 1;
    localparam int MON_RISE_BIT = 2;
    localparam int MON_LIVE_BIT = 3;
    localparam int MON_CLIP_BIT = 4;

    // ========================================================================
    // Version word field positions.
    localparam int VER_REV_LSB    = 0;
    localparam int VER_VAR_LSB    = 8;
    localparam int VER_FAMILY_LSB = 12;
endpackage : cip_monitor_pkg

// file: core/sticky_flag.sv
// One sticky status flag with set-over-clear priority.
// Assumes set and clear are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);
    // ========================================================================
    // Flag storage.
    logic flag_q;

    // set beats clear: an event in the clearing cycle survives.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            flag_q <= 1'b0;
        end else if (i_set) begin
            flag_q <= 1'b1;
        end else if (i_clear) begin
            flag_q <= 1'b0;
        end
    end

    assign o_flag = flag_q;
endmodule : sticky_flag
`default_nettype wire

// file: core/component_input_control_monitor.sv
// Component input control register bank and fast-blank / clip monitor.
// Assumes a decoded sub-address register port from the two-wire control bus
// and a fast-blank pin that is asynchronous to the processor clock.
`timescale 1ns/1ps
`default_nettype none
module component_input_control_monitor #(
    parameter logic [7:0] REVISION_ID    = 8'h01, // Arbitrary value.
    parameter logic [3:0] VARIANT_CODE   = 4'h0,  // Arbitrary value.
    parameter logic [3:0] FAMILY_CODE    = 4'h0   // Arbitrary value.
) (
    input  wire logic                                    i_clk_sys,
    input  wire logic                                    i_rst,
    input  wire logic [cip_monitor_pkg::ADDR_W-1:0]      i_sub_addr,
    input  wire logic                                    i_wr_strobe,
    input  wire logic [cip_monitor_pkg::DATA_W-1:0]      i_wr_data,
    input  wire logic                                    i_rd_strobe,
    output logic [cip_monitor_pkg::DATA_W-1:0]           o_rd_data,
    output logic                                         o_rd_valid,
    input  wire logic                                    i_fast_blank_input,
    input  wire logic signed [cip_monitor_pkg::FB_W-1:0] i_fb_measured,
    input  wire logic                                    i_clip_detect,
    output logic signed [cip_monitor_pkg::FB_W-1:0]      o_fb_value,
    output logic                                         o_extended_converter_range,
    output logic                                         o_component_port_select,
    output logic                                         o_blank_clamp_enable,
    output logic                                         o_chroma_decimation_bypass,
    output logic                                         o_yuv_input_select
);
    import cip_monitor_pkg::*;

    // ========================================================================
    // Declarations.
    logic                    xar_q;
    logic                    port_q;
    logic                    clamp_q;
    logic                    bypass_q;
    logic                    yuv_q;
    logic [OFFS_W-1:0]       offset_q;
    logic                    fb_meta_q;
    logic                    fb_sync_q;
    logic                    fb_prev_q;
    logic                    fb_rise;
    logic                    fb_fall;
    logic                    wr_ctl;
    logic                    wr_mix;
    logic                    rd_mon;
    logic                    high_flag;
    logic                    fall_flag;
    logic                    rise_flag;
    logic                    clip_flag;
    logic [DATA_W-1:0]       rd_data_d;
    logic [DATA_W-1:0]       rd_data_q;
    logic                    rd_valid_q;
    logic signed [FB_W-1:0]  fb_value_q;
    logic signed [FB_W-1:0]  fb_clamped;

    assign wr_ctl = i_wr_strobe && (i_sub_addr == ADDR_CONTROL);
    assign wr_mix = i_wr_strobe && (i_sub_addr == ADDR_SOFTMIX2);
    assign rd_mon = i_rd_strobe && (i_sub_addr == ADDR_MONITOR);

    // ========================================================================
    // Control register. Reserved bits 0, 3 and 4 are simply not stored, so a
    // host that breaks the write-zero convention cannot disturb anything.
    // defaults on reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            xar_q    <= RST_XAR;
            port_q   <= RST_PORT;
            clamp_q  <= RST_CLAMP;
            bypass_q <= RST_BYPASS;
            yuv_q    <= RST_YUV;
        end else if (wr_ctl) begin
            xar_q    <= i_wr_data[CTL_XAR_BIT];
            port_q   <= i_wr_data[CTL_PORT_BIT];
            clamp_q  <= i_wr_data[CTL_CLAMP_BIT];
            bypass_q <= i_wr_data[CTL_BYPASS_BIT];
            yuv_q    <= i_wr_data[CTL_YUV_BIT];
        end
    end

    // ========================================================================
    // Softmixer offset register; only the 6-bit offset field is held here.
    // offset setting storage
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            offset_q <= RST_OFFSET;
        end else if (wr_mix) begin
            offset_q <= i_wr_data[OFFS_W-1:0];
        end
    end

    // ========================================================================
    // Fast-blank synchroniser; only the second stage feeds the detectors.
    // two-stage sync then edge detect
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            fb_meta_q <= 1'b0;
            fb_sync_q <= 1'b0;
            fb_prev_q <= 1'b0;
        end else begin
            fb_meta_q <= i_fast_blank_input;
            fb_sync_q <= fb_meta_q;
            fb_prev_q <= fb_sync_q;
        end
    end

    assign fb_rise = fb_sync_q && !fb_prev_q;
    assign fb_fall = !fb_sync_q && fb_prev_q;

    // ========================================================================
    // Sticky monitor flags.
    // high flag cleared only when low
    sticky_flag u_high_flag (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_set     (fb_sync_q),
        .i_clear   (rd_mon && !fb_sync_q),
        .o_flag    (high_flag)
    );

    sticky_flag u_fall_flag (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_set     (fb_fall),
        .i_clear   (rd_mon),
        .o_flag    (fall_flag)
    );

    sticky_flag u_rise_flag (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_set     (fb_rise),
        .i_clear   (rd_mon),
        .o_flag    (rise_flag)
    );

    sticky_flag u_clip_flag (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_set     (i_clip_detect),
        .i_clear   (rd_mon),
        .o_flag    (clip_flag)
    );

    // ========================================================================
    // Fast-blank value path. The clamp result can go negative for offsets
    // above 31, which is why the value is carried signed.
    // clamp to 31 minus offset
    assign fb_clamped = $signed(FB_CLAMP_BASE - {1'b0, offset_q});

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            fb_value_q <= '0;
        end else if (clamp_q) begin
            fb_value_q <= fb_clamped;
        end else begin
            fb_value_q <= i_fb_measured;
        end
    end

    // ========================================================================
    // Read multiplexer. Flags are sampled in the same cycle the clear lands,
    // so the host sees the state before the clear. Unmapped reads give zero.
    always_comb begin
        rd_data_d = '0;
        case (i_sub_addr)
            ADDR_CONTROL: begin
                rd_data_d[CTL_XAR_BIT]    = xar_q;
                rd_data_d[CTL_PORT_BIT]   = port_q;
                rd_data_d[CTL_CLAMP_BIT]  = clamp_q;
                rd_data_d[CTL_BYPASS_BIT] = bypass_q;
                rd_data_d[CTL_YUV_BIT]    = yuv_q;
            end
            ADDR_SOFTMIX2: begin
                rd_data_d[OFFS_W-1:0] = offset_q;
            end
            ADDR_MONITOR: begin
                rd_data_d[MON_HIGH_BIT] = high_flag;
                rd_data_d[MON_FALL_BIT] = fall_flag;
                rd_data_d[MON_RISE_BIT] = rise_flag;
                rd_data_d[MON_LIVE_BIT] = fb_sync_q;
                rd_data_d[MON_CLIP_BIT] = clip_flag;
            end
            ADDR_VERSION: begin
                rd_data_d[VER_REV_LSB +: $bits(REVISION_ID)]    = REVISION_ID;
                rd_data_d[VER_VAR_LSB +: $bits(VARIANT_CODE)]   = VARIANT_CODE;
                rd_data_d[VER_FAMILY_LSB +: $bits(FAMILY_CODE)] = FAMILY_CODE;
            end
            default: begin
                rd_data_d = '0;
            end
        endcase
    end

    // Read data is held until the next read so a slow bus can fetch it.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_data_q  <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_strobe;
            if (i_rd_strobe) begin
                rd_data_q <= rd_data_d;
            end
        end
    end

    // ========================================================================
    // Outputs.
    assign o_rd_data                  = rd_data_q;
    assign o_rd_valid                 = rd_valid_q;
    assign o_fb_value                 = fb_value_q;
    assign o_extended_converter_range = xar_q;
    assign o_component_port_select    = port_q;
    assign o_blank_clamp_enable       = clamp_q;
    assign o_chroma_decimation_bypass = bypass_q;
    assign o_yuv_input_select         = yuv_q;

    // ========================================================================
    // Assertions.
    property p_xar_write;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_ctl |=> o_extended_converter_range == $past(i_wr_data[CTL_XAR_BIT]);
    endproperty
    a_xar_write: assert property (p_xar_write) else $error("Range bit not taken.");

    property p_port_write;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_ctl |=> o_component_port_select == $past(i_wr_data[CTL_PORT_BIT]);
    endproperty
    a_port_write: assert property (p_port_write) else $error("Port select not taken.");

    property p_clamp_value;
        @(posedge i_clk_sys) disable iff (i_rst)
        (clamp_q && !wr_mix) ##1 clamp_q |-> o_fb_value == $signed(FB_CLAMP_BASE - {1'b0, offset_q});
    endproperty
    a_clamp_value: assert property (p_clamp_value) else $error("Clamp value wrong.");

    property p_pass_value;
        @(posedge i_clk_sys) disable iff (i_rst)
        !clamp_q |=> o_fb_value == $past(i_fb_measured);
    endproperty
    a_pass_value: assert property (p_pass_value) else $error("Measured value not passed.");

    property p_yuv_write;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_ctl ##1 !wr_ctl [*2] |-> o_yuv_input_select == $past(i_wr_data[CTL_YUV_BIT], 2);
    endproperty
    a_yuv_write: assert property (p_yuv_write) else $error("Format bit not held.");

    property p_high_flag;
        @(posedge i_clk_sys) disable iff (i_rst)
        fb_sync_q |=> high_flag;
    endproperty
    a_high_flag: assert property (p_high_flag) else $error("High flag not set.");

    property p_fall_flag;
        @(posedge i_clk_sys) disable iff (i_rst)
        $fell(fb_sync_q) |=> fall_flag;
    endproperty
    a_fall_flag: assert property (p_fall_flag) else $error("Fall flag not set.");

    property p_rise_flag;
        @(posedge i_clk_sys) disable iff (i_rst)
        (rd_mon && fb_rise) |=> rise_flag;
    endproperty
    a_rise_flag: assert property (p_rise_flag) else $error("Rise lost on read.");

    property p_live_level;
        @(posedge i_clk_sys) disable iff (i_rst)
        rd_mon |=> o_rd_valid && o_rd_data[MON_LIVE_BIT] == $past(fb_sync_q);
    endproperty
    a_live_level: assert property (p_live_level) else $error("Live level wrong.");

    property p_clip_clear;
        @(posedge i_clk_sys) disable iff (i_rst)
        (rd_mon && !i_clip_detect) |=> !clip_flag;
    endproperty
    a_clip_clear: assert property (p_clip_clear) else $error("Clip flag not cleared.");
endmodule : component_input_control_monitor
`default_nettype wire

// file: test/host_port_model.sv
// Host controller model for the decoded sub-address register port.
// Assumes strobes are sampled on the rising clock edge of i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input  wire logic                                i_clk_sys,
    output var logic [cip_monitor_pkg::ADDR_W-1:0]   o_sub_addr,
    output var logic                                 o_wr_strobe,
    output var logic [cip_monitor_pkg::DATA_W-1:0]   o_wr_data,
    output var logic                                 o_rd_strobe,
    input  wire logic [cip_monitor_pkg::DATA_W-1:0]  i_rd_data,
    input  wire logic                                i_rd_valid
);
    import cip_monitor_pkg::*;
    // ========================================================================
    // Idle bus. Released lines show inverted values so stale data never looks live.
    initial begin
        o_sub_addr  = 8'h00;
        o_wr_strobe = 1'b0;
        o_wr_data   = 16'h0000;
        o_rd_strobe = 1'b0;
    end
    // One write; gap lets the host be prompt or slow.
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data, input int gap);
        repeat (gap) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_sub_addr  <= addr;
        o_wr_data   <= data;
        o_wr_strobe <= 1'b1;
        @(posedge i_clk_sys);
        o_wr_strobe <= 1'b0;
        o_sub_addr  <= ~addr;
        o_wr_data   <= ~data;
    endtask : write_reg
    // One read; the answer is taken in the cycle where it stands.
    task automatic read_reg(input logic [7:0] addr, input int gap, output logic [15:0] data,
                            output logic valid);
        repeat (gap) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_sub_addr  <= addr;
        o_rd_strobe <= 1'b1;
        @(posedge i_clk_sys);
        o_rd_strobe <= 1'b0;
        o_sub_addr  <= ~addr;
        #1;
        valid = i_rd_valid;
        data  = i_rd_data;
    endtask : read_reg
endmodule : host_port_model
`default_nettype wire

// file: test/component_input_control_monitor_tb.sv
// Self-checking bench for the component input control and monitor block.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module component_input_control_monitor_tb;
    import cip_monitor_pkg::*;
    localparam logic [7:0] REV  = 8'h2A; // Arbitrary value.
    localparam logic [3:0] VARC = 4'h3;  // Arbitrary value.
    localparam logic [3:0] FAM  = 4'h5;  // Arbitrary value.
    logic i_clk_sys, i_rst, wr, rd, rv, fb_pin, clip, extended_converter_range, port, clamp, bypass, yuv;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, ctl, snap;
    logic snap_v;
    logic signed [6:0] fb_meas, fb_val;
    logic [5:0] off;
    int seed, fail_count, samples_checked, cycles;
    // ========================================================================
    // Design and host model.
    component_input_control_monitor #(.REVISION_ID(REV), .VARIANT_CODE(VARC), .FAMILY_CODE(FAM)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sub_addr(addr), .i_wr_strobe(wr), .i_wr_data(wdata),
        .i_rd_strobe(rd), .o_rd_data(rdata), .o_rd_valid(rv), .i_fast_blank_input(fb_pin),
        .i_fb_measured(fb_meas), .i_clip_detect(clip), .o_fb_value(fb_val),
        .o_extended_converter_range(extended_converter_range), .o_component_port_select(port), .o_blank_clamp_enable(clamp),
        .o_chroma_decimation_bypass(bypass), .o_yuv_input_select(yuv));
    host_port_model host_u (.i_clk_sys(i_clk_sys), .o_sub_addr(addr), .o_wr_strobe(wr), .o_wr_data(wdata),
        .o_rd_strobe(rd), .i_rd_data(rdata), .i_rd_valid(rv));
    // ========================================================================
    // Clock and a cycle ceiling, so a hang still reaches the report.
    initial i_clk_sys = 1'b0;
    always #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    // Clamp output: the fixed base of 31 less the offset, may go negative.
    function automatic logic [6:0] clamp_exp(input logic [5:0] o);
        return 7'h1F - {1'b0, o};
    endfunction : clamp_exp
    // Read with a random host delay and compare the word.
    task automatic rd_check(input logic [7:0] a, input logic [15:0] ex, input string nm);
        logic [15:0] d;
        logic v;
        host_u.read_reg(a, {$random(seed)} % 3, d, v);
        `CHECK("rd_valid", 1'b1, v)
        `CHECK(nm, ex, d)
    endtask : rd_check
    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    // ========================================================================
    // Main sequence.
    initial begin
        seed = 80100;
        i_rst = 1'b1;
        fb_pin = 1'b0;
        clip = 1'b0;
        fb_meas = 7'h00;
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        `CHECK("ctl_rst", 5'b01000, {yuv, bypass, clamp, port, extended_converter_range})
        rd_check(ADDR_CONTROL, 16'h0040, "control_rst");
        rd_check(ADDR_SOFTMIX2, 16'h0020, "offset_rst");
        rd_check(ADDR_VERSION, {FAM, VARC, REV}, "version");
        rd_check(8'h55, 16'h0000, "unmapped");
        host_u.write_reg(ADDR_VERSION, 16'hFFFF, 0);
        host_u.write_reg(ADDR_MONITOR, 16'h00FF, 0);
        rd_check(ADDR_VERSION, {FAM, VARC, REV}, "version_ro");
        rd_check(ADDR_MONITOR, 16'h0000, "monitor_idle");
        // Random control words with the reserved bits kept clear.
        for (int i = 0; i < 12; i++) begin
            ctl = 16'($random(seed)) & 16'h00E6;
            host_u.write_reg(ADDR_CONTROL, ctl, i % 2);
            @(posedge i_clk_sys);
            #1;
            `CHECK("ctl_fields", {ctl[7:5], ctl[2:1]}, {yuv, bypass, clamp, port, extended_converter_range})
            rd_check(ADDR_CONTROL, ctl, "control_rd");
        end
        // Clamp against pass-through, offset corners first.
        for (int i = 0; i < 8; i++) begin
            off = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : 6'($random(seed));
            host_u.write_reg(ADDR_SOFTMIX2, {10'h000, off}, 0);
            host_u.write_reg(ADDR_CONTROL, (i < 5) ? 16'h0060 : 16'h0040, 0);
            fb_meas <= 7'($random(seed));
            repeat (3) @(posedge i_clk_sys);
            #1;
            `CHECK("fb_value", (i < 5) ? clamp_exp(off) : 7'(fb_meas), 7'(fb_val))
        end
        // Single rise, hold, single fall.
        fb_pin <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        rd_check(ADDR_MONITOR, 16'h000D, "mon_rise");
        rd_check(ADDR_MONITOR, 16'h0009, "mon_high_hold");
        fb_pin <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        rd_check(ADDR_MONITOR, 16'h0003, "mon_fall");
        rd_check(ADDR_MONITOR, 16'h0000, "mon_cleared");
        // Random pulse train ending low.
        for (int i = 0; i < 4; i++) begin
            fb_pin <= ~fb_pin;
            repeat (3 + {$random(seed)} % 4) @(posedge i_clk_sys);
        end
        repeat (4) @(posedge i_clk_sys);
        rd_check(ADDR_MONITOR, 16'h0007, "mon_train");
        // Clip held high across a clearing read keeps its flag.
        clip <= 1'b1;
        rd_check(ADDR_MONITOR, 16'h0010, "clip_set");
        clip <= 1'b0;
        rd_check(ADDR_MONITOR, 16'h0010, "clip_kept");
        rd_check(ADDR_MONITOR, 16'h0000, "clip_cleared");
        // A read strobe that lands on the synchronised rising edge must not lose the event.
        fb_pin <= 1'b1;
        host_u.read_reg(ADDR_MONITOR, 1, snap, snap_v);
        `CHECK("mon_rise_on_read", 16'h0008, snap)
        rd_check(ADDR_MONITOR, 16'h000D, "mon_rise_kept");
        // Second reset in mid-run restores the defaults.
        host_u.write_reg(ADDR_CONTROL, 16'h00A6, 0);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        `CHECK("ctl_rerst", 5'b01000, {yuv, bypass, clamp, port, extended_converter_range})
        rd_check(ADDR_SOFTMIX2, 16'h0020, "offset_rerst");
        summarize();
    end
endmodule : component_input_control_monitor_tb
`default_nettype wire
